/* rtl/srac_pkg.sv */
package srac_pkg;
  // Command byte field positions, most significant bit first.
  localparam int ZERO_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 4;
  localparam int DIR_BIT = 3;
  localparam int PDN_BIT = 2;
  localparam int CH_HI = 1;
  localparam int CH_LO = 0;
  // Widths of the serial frames.
  localparam int CMD_BITS = 8;
  localparam logic [5:0] LEN_8 = 6'h08;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_24 = 6'h18;
  // Run of ones that forces the interface back to idle.
  localparam logic [5:0] RESYNC_ONES = 6'h20;
  // Reset values.
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h01;
  localparam logic [7:0] CLOCK_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [23:0] CAL_RESET = 24'h000000;

  // Register select codes.
  typedef enum logic [2:0] {
    SEL_CMD = 3'h0,
    SEL_SETUP = 3'h1,
    SEL_CLOCK = 3'h2,
    SEL_RESULT = 3'h3,
    SEL_TEST = 3'h4,
    SEL_NOP = 3'h5,
    SEL_ZERO_CAL = 3'h6,
    SEL_FULL_CAL = 3'h7
  } srac_sel_type;

  // Input channel codes.
  typedef enum logic [1:0] {
    CH_IN_ONE = 2'h0,
    CH_IN_TWO = 2'h1,
    CH_SHORT = 2'h2,
    CH_HIGH = 2'h3
  } srac_ch_type;

  // Serial interface states.
  typedef enum logic [1:0] {
    ST_WAIT_ZERO = 2'h0,
    ST_CMD = 2'h1,
    ST_WRITE = 2'h2,
    ST_READ = 2'h3
  } srac_state_type;

  // Decoded command register contents.
  typedef struct packed {
    srac_sel_type sel;
    logic dir_read;
    logic power_down_request;
    srac_ch_type ch;
  } srac_cmd_type;

  // Configuration presented to the converter core.
  typedef struct packed {
    logic standby;
    srac_ch_type input_sel;
    logic [1:0] cal_pair;
    logic [7:0] setup;
    logic [7:0] clock_cfg;
    logic [7:0] test;
  } srac_cfg_type;
endpackage : srac_pkg

/* rtl/srac_serial_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module srac_serial_ctrl (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Serial pins from the host.
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  // Converter core status.
  input wire logic conversion_ready_flag,
  input wire logic [15:0] conversion_result,
  input wire logic cal_valid,
  input wire logic [23:0] cal_zero_in,
  input wire logic [23:0] cal_full_in,
  // Configuration and status toward the core and pins.
  output srac_pkg::srac_cfg_type cfg,
  output logic ready_pin,
  output logic [23:0] zero_scale_calibration,
  output logic [23:0] full_scale_calibration
);

  // Two-stage synchronisers for the serial pins.
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  // Previous synchronised clock level, for edge detection.
  logic sclk_prev;
  // Edge strobes on the synchronised serial clock.
  logic sclk_rise;
  logic sclk_fall;
  // Interface state and bit counters.
  srac_pkg::srac_state_type state;
  logic [5:0] bit_cnt;
  logic [5:0] frame_len;
  logic [5:0] ones_cnt;
  // Shift registers for write and read data.
  logic [23:0] shift_in;
  logic [23:0] shift_out;
  // Command register fields.
  srac_pkg::srac_cmd_type cmd;
  // Configuration registers.
  logic [7:0] setup_register;
  logic [7:0] clock_register;
  logic [7:0] test_register;
  // Calibration pairs, indexed by pair number.
  logic [23:0] zero_cal [3];
  logic [23:0] full_cal [3];
  // Calibration pair chosen by the current channel.
  logic [1:0] pair_idx;
  // Calibration pair named by the command byte now arriving.
  logic [1:0] next_pair_idx;
  // Frame end and resynchronisation strobes.
  logic frame_done;
  logic resync;
  // Incoming command with the new sample shifted in.
  logic [7:0] next_cmd_byte;

  // Synchronise the asynchronous pins before any logic looks at them.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // The clock resets to its idle high level so no false edge follows.
      sclk_sync <= 2'h3;
      din_sync <= 2'h0;
      sclk_prev <= 1'h1;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk};
      din_sync <= {din_sync[0], din};
      sclk_prev <= sclk_sync[1];
    end
  end

  // Data is sampled on rising edges and shifted out on falling edges.
  assign sclk_rise = sclk_sync[1] && !sclk_prev;
  assign sclk_fall = !sclk_sync[1] && sclk_prev;

  always_comb begin
    case (cmd.ch)
      // Second low-level input owns the middle pair.
      srac_pkg::CH_IN_TWO: pair_idx = 2'h1;
      // High-level input owns the last pair.
      srac_pkg::CH_HIGH: pair_idx = 2'h2;
      // First input and the shorted self-test share the first pair.
      default: pair_idx = 2'h0;
    endcase
  end

  // Pair routing for reads
  // A read opens in the cycle that stores the command, so its pair comes
  // from the incoming channel bits and not from the stored ones.
  always_comb begin
    case (next_cmd_byte[srac_pkg::CH_HI:srac_pkg::CH_LO])
      // Second low-level input owns the middle pair.
      srac_pkg::CH_IN_TWO: next_pair_idx = 2'h1;
      // High-level input owns the last pair.
      srac_pkg::CH_HIGH: next_pair_idx = 2'h2;
      // First input and the shorted self-test share the first pair.
      default: next_pair_idx = 2'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ones_cnt <= 6'h00;
    end else if (sclk_rise) begin
      if (!din_sync[1]) begin
        // A zero breaks the run.
        ones_cnt <= 6'h00;
      end else if (ones_cnt != srac_pkg::RESYNC_ONES) begin
        // Saturate so that a longer run cannot wrap round.
        ones_cnt <= ones_cnt + 6'h01;
      end
    end
  end

  // A run of ones that reaches the threshold forces the idle state.
  assign resync = sclk_rise && din_sync[1]
                  && (ones_cnt == srac_pkg::RESYNC_ONES - 6'h01);

  // Last bit of the current register frame is being taken.
  assign frame_done = sclk_rise && (bit_cnt == frame_len - 6'h01);
  // The eight most recent samples, the newest in the lowest bit.
  assign next_cmd_byte = {shift_in[6:0], din_sync[1]};

  // Serial interface sequencer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= srac_pkg::ST_WAIT_ZERO;
      bit_cnt <= 6'h00;
      frame_len <= srac_pkg::LEN_8;
    end else if (resync) begin
      state <= srac_pkg::ST_WAIT_ZERO;
      bit_cnt <= 6'h00;
    end else if (sclk_rise) begin
      case (state)
        srac_pkg::ST_WAIT_ZERO: begin
          if (!din_sync[1]) begin
            state <= srac_pkg::ST_CMD;
            bit_cnt <= 6'h01;
          end
        end
        srac_pkg::ST_CMD: begin
          // Count the bits of the command byte.
          bit_cnt <= bit_cnt + 6'h01;
          if (bit_cnt == 6'(srac_pkg::CMD_BITS - 1)) begin
            bit_cnt <= 6'h00;
            case (next_cmd_byte[srac_pkg::SEL_HI:srac_pkg::SEL_LO])
              srac_pkg::SEL_RESULT: frame_len <= srac_pkg::LEN_16;
              srac_pkg::SEL_ZERO_CAL,
              srac_pkg::SEL_FULL_CAL: frame_len <= srac_pkg::LEN_24;
              default: frame_len <= srac_pkg::LEN_8;
            endcase
            if (next_cmd_byte[srac_pkg::SEL_HI:srac_pkg::SEL_LO]
                == srac_pkg::SEL_NOP) begin
              state <= srac_pkg::ST_WAIT_ZERO;
            end else if (next_cmd_byte[srac_pkg::DIR_BIT]) begin
              state <= srac_pkg::ST_READ;
            end else begin
              state <= srac_pkg::ST_WRITE;
            end
          end
        end
        srac_pkg::ST_WRITE, srac_pkg::ST_READ: begin
          // Reads and writes share the frame counter.
          bit_cnt <= bit_cnt + 6'h01;
          if (frame_done) begin
            state <= srac_pkg::ST_WAIT_ZERO;
            bit_cnt <= 6'h00;
          end
        end
        default: begin
          // Unused state codes fall back to idle.
          state <= srac_pkg::ST_WAIT_ZERO;
        end
      endcase
    end
  end

  // Input shift register, most significant bit first.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 24'h000000;
    end else if (sclk_rise) begin
      // Every sampled bit enters, command and data alike.
      shift_in <= {shift_in[22:0], din_sync[1]};
    end
  end

  // Command register load at the eighth bit of a command byte.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= srac_pkg::srac_cmd_type'(srac_pkg::CMD_RESET[6:0]);
    end else if (!resync && sclk_rise && state == srac_pkg::ST_CMD
                 && bit_cnt == 6'(srac_pkg::CMD_BITS - 1)) begin
      cmd <= srac_pkg::srac_cmd_type'(next_cmd_byte[6:0]);
    end
  end

  // Configuration registers written at the end of a write frame.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setup_register <= srac_pkg::SETUP_RESET;
      clock_register <= srac_pkg::CLOCK_RESET;
      test_register <= srac_pkg::TEST_RESET;
    end else if (!resync && frame_done && state == srac_pkg::ST_WRITE) begin
      // Writes during standby
      // Command, result and no-operation selects store nothing here.
      case (cmd.sel)
        srac_pkg::SEL_SETUP: setup_register <= next_cmd_byte;
        srac_pkg::SEL_CLOCK: clock_register <= next_cmd_byte;
        srac_pkg::SEL_TEST: test_register <= next_cmd_byte;
        default: ;
      endcase
    end
  end

  // Calibration pairs: host writes or core calibration results.
  generate
    for (genvar p = 0; p < 3; p++) begin : g_pair
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          zero_cal[p] <= srac_pkg::CAL_RESET;
          full_cal[p] <= srac_pkg::CAL_RESET;
        // Only the pair of the current channel takes writes or results.
        end else if (pair_idx == 2'(p)) begin
          if (!resync && frame_done && state == srac_pkg::ST_WRITE
              && cmd.sel == srac_pkg::SEL_ZERO_CAL) begin
            zero_cal[p] <= {shift_in[22:0], din_sync[1]};
          end else if (!resync && frame_done
                       && state == srac_pkg::ST_WRITE
                       && cmd.sel == srac_pkg::SEL_FULL_CAL) begin
            full_cal[p] <= {shift_in[22:0], din_sync[1]};
          end else if (cal_valid && !cmd.power_down_request) begin
            zero_cal[p] <= cal_zero_in;
            full_cal[p] <= cal_full_in;
          end
        end
      end
    end
  endgenerate

  // Output shift register: loaded when a read frame opens.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out <= 24'h000000;
    end else if (sclk_rise && state == srac_pkg::ST_CMD
                 && bit_cnt == 6'(srac_pkg::CMD_BITS - 1)) begin
      case (next_cmd_byte[srac_pkg::SEL_HI:srac_pkg::SEL_LO])
        srac_pkg::SEL_CMD: shift_out <= {conversion_ready_flag,
                                         next_cmd_byte[6:0], 16'h0000};
        srac_pkg::SEL_SETUP: shift_out <= {setup_register, 16'h0000};
        srac_pkg::SEL_CLOCK: shift_out <= {clock_register, 16'h0000};
        srac_pkg::SEL_RESULT: shift_out <= {conversion_result, 8'h00};
        srac_pkg::SEL_TEST: shift_out <= {test_register, 16'h0000};
        // Calibration reads follow the incoming channel bits.
        srac_pkg::SEL_ZERO_CAL: shift_out <= zero_cal[next_pair_idx];
        srac_pkg::SEL_FULL_CAL: shift_out <= full_cal[next_pair_idx];
        // The no-operation code has nothing to send.
        default: shift_out <= 24'h000000;
      endcase
    end else if (sclk_fall && state == srac_pkg::ST_READ
                 && bit_cnt != 6'h00) begin
      // The first bit already stands, so shifting starts one edge later.
      shift_out <= {shift_out[22:0], 1'h0};
    end
  end

  // Serial output pin and its enable, driven only during read frames.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= 1'h0;
      dout_oe_n <= 1'h1;
    end else begin
      dout <= shift_out[23];
      // Only a read frame turns the pin driver on.
      dout_oe_n <= (state != srac_pkg::ST_READ);
    end
  end

  // Configuration toward the converter core.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Configuration copies start from the register reset values.
      cfg <= srac_pkg::srac_cfg_type'({5'h00, srac_pkg::SETUP_RESET,
                                       srac_pkg::CLOCK_RESET,
                                       srac_pkg::TEST_RESET});
      ready_pin <= 1'h0;
      zero_scale_calibration <= srac_pkg::CAL_RESET;
      full_scale_calibration <= srac_pkg::CAL_RESET;
    end else begin
      // Every copy refreshes each cycle from its source register or status input.
      // Standby from command
      cfg.standby <= cmd.power_down_request;
      cfg.input_sel <= cmd.ch;
      cfg.cal_pair <= pair_idx;
      cfg.setup <= setup_register;
      cfg.clock_cfg <= clock_register;
      cfg.test <= test_register;
      ready_pin <= conversion_ready_flag;
      // Calibration outputs show the pair of the current channel.
      zero_scale_calibration <= zero_cal[pair_idx];
      full_scale_calibration <= full_cal[pair_idx];
    end
  end

endmodule : srac_serial_ctrl
`default_nettype wire

/* sim/srac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial port: drives the link clock and data-in.
module srac_host_model (
  // Serial pins toward the device.
  output logic sclk,
  output logic din,
  input wire logic dout
);
  // The link clock rests high between frames.
  initial begin
    sclk = 1'b1;
    din = 1'b0;
  end
  // MSB first
  // Sends n bits from the top of bits; read bits are taken at rising edges.
  task automatic xfer(input logic [31:0] bits, input int n,
                      output logic [31:0] r);
    r = 32'h00000000;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din = bits[31 - i];
      #24;
      sclk = 1'b1;
      r = {r[30:0], dout};
      #24;
    end
  endtask : xfer
endmodule : srac_host_model
`default_nettype wire

/* sim/srac_serial_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the serial command front end.
module srac_serial_ctrl_properties (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Observed ports.
  input wire logic dout_oe_n,
  input wire logic conversion_ready_flag,
  input wire logic cal_valid,
  input wire logic [23:0] cal_zero_in,
  input wire logic [23:0] cal_full_in,
  input wire srac_pkg::srac_cfg_type cfg,
  input wire logic ready_pin,
  input wire logic [23:0] zero_scale_calibration,
  input wire logic [23:0] full_scale_calibration
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Counts cycles of one read frame.
  logic [8:0] low_cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 9'h000;
    end else begin
      low_cnt <= dout_oe_n ? 9'h000 : low_cnt + 9'h001;
    end
  end
  // A read frame drives for at least eight cycles.
  sequence s_read_hold;
    !dout_oe_n [*8];
  endsequence
  a_reset_vals: assert property ($rose(rst_n) |->
    cfg.setup == 8'h01 && !cfg.standby && dout_oe_n)
    else $error("reset values wrong");
  a_ready_copy: assert property ($past(rst_n) |->
    ready_pin == $past(conversion_ready_flag))
    else $error("ready pin wrong");
  a_pair_map: assert property ($stable(cfg.input_sel) |->
    cfg.cal_pair == (cfg.input_sel == 2'h3 ? 2'h2 :
    cfg.input_sel == 2'h1 ? 2'h1 : 2'h0))
    else $error("pair map wrong");
  a_cal_store: assert property (cal_valid && !cfg.standby |->
    ##[1:2] zero_scale_calibration == cal_zero_in &&
    full_scale_calibration == cal_full_in)
    else $error("cal not stored");
  a_cal_hold: assert property (cal_valid && cfg.standby |->
    ##2 $stable(zero_scale_calibration) && $stable(full_scale_calibration))
    else $error("cal changed in standby");
  a_oe_min: assert property ($fell(dout_oe_n) |-> s_read_hold)
    else $error("read frame short");
  a_read_bound: assert property (low_cnt <= 9'h104)
    else $error("read frame long");
  a_power_down_request_edge: assert property ($changed(cfg.standby) |->
    $past(dout_oe_n))
    else $error("standby changed mid read");
endmodule : srac_serial_ctrl_properties
bind srac_serial_ctrl srac_serial_ctrl_properties chk_u (
  .mclk(mclk), .rst_n(rst_n), .dout_oe_n(dout_oe_n),
  .conversion_ready_flag(conversion_ready_flag), .cal_valid(cal_valid),
  .cal_zero_in(cal_zero_in), .cal_full_in(cal_full_in), .cfg(cfg),
  .ready_pin(ready_pin), .zero_scale_calibration(zero_scale_calibration),
  .full_scale_calibration(full_scale_calibration)
);
`default_nettype wire

/* sim/srac_serial_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Command sequences over the serial port with expected values.
module srac_serial_ctrl_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rdy = 1'b0;
  logic [15:0] res = 16'hBEEF;
  logic cal_valid = 1'b0;
  logic [23:0] cz = 24'h000000;
  logic [23:0] cf = 24'h000000;
  wire logic sclk, din, dout, dout_oe_n, ready_pin;
  wire logic dout_pin;
  // The host sees the inverse of the last level while nobody drives.
  assign dout_pin = dout_oe_n ? ~dout : dout;
  wire logic [23:0] zsc, fsc;
  srac_pkg::srac_cfg_type cfg;
  logic [31:0] rd;
  int num_errors = 0;
  int cmp_count = 0;
  int lc;
  always #2.5 mclk = ~mclk;
  srac_serial_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .conversion_ready_flag(rdy), .conversion_result(res),
    .cal_valid(cal_valid), .cal_zero_in(cz), .cal_full_in(cf), .cfg(cfg),
    .ready_pin(ready_pin), .zero_scale_calibration(zsc),
    .full_scale_calibration(fsc));
  srac_host_model host_u (.sclk(sclk), .din(din), .dout(dout_pin));
  // Reports a mismatch and counts every comparison.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // One command byte, then an optional frame of n bits.
  task automatic acc(input logic [7:0] cmd, input logic [23:0] v,
                     input int n);
    host_u.xfer({cmd, 24'h000000}, 8, rd);
    if (n > 0) begin
      host_u.xfer({v << (24 - n), 8'h00}, n, rd);
    end
  endtask : acc
  // One calibration result from the core.
  task automatic pulse(input logic [23:0] z, input logic [23:0] f);
    @(negedge mclk);
    cz = z;
    cf = f;
    cal_valid = 1'b1;
    @(negedge mclk);
    cal_valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : pulse
  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence.
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    acc(8'h18, 24'h0, 8);
    check(rd, 32'h01);
    for (int s = 0; s < 3; s++) begin
      lc = (s == 0) ? 1 : (s == 1) ? 2 : 4;
      acc({1'b0, lc[2:0], 4'h0}, 24'h3C + 24'(s), 8);
      acc({1'b0, lc[2:0], 4'h8}, 24'h0, 8);
      check(rd, 32'h3C + s);
    end
    check({cfg.setup, cfg.clock_cfg, cfg.test}, 32'h3C3D3E);
    acc(8'h30, 24'h1234, 16);
    acc(8'h38, 24'h0, 16);
    check(rd, 32'hBEEF);
    @(negedge mclk);
    rdy = 1'b1;
    acc(8'h08, 24'h0, 8);
    check(rd, 32'h88);
    check(ready_pin, 1'b1);
    host_u.xfer({3'h7, 8'h18, 21'h0}, 11, rd);
    host_u.xfer(32'h0, 8, rd);
    check(rd, 32'h3C);
    acc(8'h54, 24'h0, 0);
    check(cfg.standby, 1'b1);
    pulse(24'hFFFFFF, 24'hFFFFFF);
    check(zsc, 24'h0);
    acc(8'h1C, 24'h0, 8);
    check(rd, 32'h3C);
    acc(8'h50, 24'h0, 0);
    check(cfg.standby, 1'b0);
    for (int c = 0; c < 4; c++) begin
      acc({6'h14, c[1:0]}, 24'h0, 0);
      pulse(24'hA00000 + 24'(c), 24'h500000 + 24'(c));
      check(cfg.input_sel, c[1:0]);
      check(cfg.cal_pair, (c == 3) ? 2 : c % 2);
      check(zsc, 24'hA00000 + c);
    end
    for (int c = 0; c < 4; c++) begin
      lc = (c == 0) ? 2 : c;
      acc({6'h1A, c[1:0]}, 24'h0, 24);
      check(rd, 32'hA00000 + lc);
      acc({6'h1E, c[1:0]}, 24'h0, 24);
      check(rd, 32'h500000 + lc);
    end
    acc(8'h73, 24'hC0FFEE, 24);
    acc(8'h7B, 24'h0, 24);
    check(rd, 32'hC0FFEE);
    check(fsc, 24'hC0FFEE);
    host_u.xfer({8'h10, 24'h0}, 8, rd);
    host_u.xfer({3'h2, 29'h1FFFFFFF}, 32, rd);
    host_u.xfer(32'hFFFFFFFF, 8, rd);
    acc(8'h18, 24'h0, 8);
    check(rd, 32'h5F);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    acc(8'h18, 24'h0, 8);
    check(rd, 32'h01);
    check(cfg.input_sel, 2'h0);
    tally_and_finish();
  end
  // Cuts a hang short.
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule : srac_serial_ctrl_tb_top
`default_nettype wire
